// ===== verilog/serial_port_control.sv
/*
  control register bank and pin steering of a synchronous serial port
  that works as spi master or slave or as i2c master or slave.
  assumes a classic wishbone master on clk_i, a shift datapath on the
  same clock that reports transfer events, and port direction bits kept
  by software outside this block.
*/
// Implementation choices: the placing of the registers and the Wishbone register port.
// Overview of operation
// - i2c master buffer write when bus cannot start sets write collision
// - slave buffer write while previous word still shifting sets write collision
// - spi slave byte arriving over unread buffer sets overflow, old data kept
// - spi master never raises the receive overflow flag
// - port enable in spi hands sck, sdo and sdi to port, and ss too in mode 0100
// - clearing port enable returns pins to general purpose use
// - port enable in i2c hands sda and scl to the port
// - in spi the polarity bit sets the idle clock level
// - i2c slave: polarity bit zero holds scl low, one releases it
// - codes 0000, 0001, 0010 give spi master at clock over 4, 16, 64
// - 0100 spi slave using ss, 0101 spi slave ignoring ss
// - mode codes give i2c slave with 7-bit or 10-bit address
// - 1100, 1101 and other reserved codes select no mode
`timescale 1ns/1ps
module serial_port_control
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // shift datapath events, same clock
  input wire logic start_ok_i,
  input wire logic tx_busy_i,
  input wire logic i2c_transmit_i,
  input wire logic rx_done_i,
  input wire logic [7:0] rx_data_i,
  input wire logic sdo_bit_i,
  input wire logic sda_low_i,
  input wire logic timer_pulse_i,
  // to shift datapath
  output logic tx_load_o,
  output logic [7:0] tx_data_o,
  output logic master_tick_o,
  output logic sck_in_o,
  output logic sdi_in_o,
  output logic ss_active_o,
  output logic sda_in_o,
  output logic scl_in_o,
  output logic spi_master_o,
  output logic spi_slave_o,
  output logic i2c_slave_o,
  output logic i2c_ten_bit_o,
  output logic i2c_master_o,
  // general purpose port side
  input wire logic [serial_port_pkg::PIN_N-1:0] gpio_out_i,
  input wire logic [serial_port_pkg::PIN_N-1:0] gpio_oe_n_i,
  output logic [serial_port_pkg::PIN_N-1:0] gpio_in_o,
  // pads
  input wire logic [serial_port_pkg::PIN_N-1:0] pin_i,
  output logic [serial_port_pkg::PIN_N-1:0] pin_o,
  output logic [serial_port_pkg::PIN_N-1:0] pin_oe_n_o
);

  localparam int N = serial_port_pkg::PIN_N;

  // control register fields
  logic write_collision_flag_reg;
  logic write_collision_flag_next;
  logic ovf_reg;
  logic ovf_next;
  logic en_reg;
  logic en_next;
  logic ckp_reg;
  logic ckp_next;
  logic [3:0] mode_reg;
  logic [3:0] mode_next;
  logic [7:0] reload_reg;
  logic [7:0] reload_next;
  logic [7:0] rxbuf_reg;
  logic [7:0] rxbuf_next;
  logic full_reg;
  logic full_next;
  logic [7:0] txbuf_reg;
  logic [7:0] txbuf_next;
  logic load_reg;
  logic load_next;

  // bus state
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // pin synchronisers and master clock
  logic [N-1:0] pin_meta_reg;
  logic [N-1:0] pin_sync_reg;
  logic sck_tog_reg;
  logic sck_tog_next;

  // decoded mode
  logic dec_spi_m;
  logic dec_spi_s;
  logic dec_ss_used;
  logic dec_i2c_s;
  logic dec_i2c_10;
  logic dec_i2c_mhw;
  logic dec_i2c_mfw;
  logic dec_valid;
  serial_port_pkg::clk_src_e dec_src;
  logic [serial_port_pkg::DIV_W-1:0] dec_half;
  logic tick;

  // access strobes
  logic acc;
  logic wr;
  logic rd;
  logic wr_ctrl;
  logic wr_buf;
  logic rd_buf;
  logic slave_mode;
  logic master_mode;
  logic i2c_mode;
  logic spi_mode;
  logic collide;
  logic rx_overflow;

  port_mode_decode port_mode_decode_inst
  (
    .mode_i(mode_reg),
    .spi_master_o(dec_spi_m),
    .spi_slave_o(dec_spi_s),
    .ss_used_o(dec_ss_used),
    .i2c_slave_o(dec_i2c_s),
    .i2c_ten_bit_o(dec_i2c_10),
    .i2c_master_hw_o(dec_i2c_mhw),
    .i2c_master_fw_o(dec_i2c_mfw),
    .mode_valid_o(dec_valid),
    .clk_src_o(dec_src),
    .fixed_half_o(dec_half)
  );

  clock_tick_divider clock_tick_divider_inst
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(en_reg & (dec_spi_m | dec_i2c_mhw) & tx_busy_i),
    .src_i(dec_src),
    .fixed_half_i(dec_half),
    .reload_i(reload_reg),
    .timer_pulse_i(timer_pulse_i),
    .tick_o(tick)
  );

  // bus access happens at the edge where ack is seen by the master
  assign acc = cyc_i & stb_i & ack_reg;
  assign wr = acc & we_i & sel_i[0];
  assign rd = acc & ~we_i;
  assign wr_ctrl = wr & (adr_i == serial_port_pkg::CTRL_OFS);
  assign wr_buf = wr & (adr_i == serial_port_pkg::BUF_OFS);
  assign rd_buf = rd & (adr_i == serial_port_pkg::BUF_OFS);

  // no mode is active while the port is off or the code is reserved
  assign spi_mode = en_reg & (dec_spi_m | dec_spi_s);
  assign i2c_mode = en_reg & (dec_i2c_s | dec_i2c_mhw | dec_i2c_mfw);
  assign slave_mode = en_reg & (dec_spi_s | dec_i2c_s);
  assign master_mode = en_reg & (dec_i2c_mhw | dec_i2c_mfw);

  // collision on a buffer write the port cannot take
  always_comb
  begin
    collide = 1'b0;
    if (wr_buf && master_mode && !start_ok_i)
    begin
      collide = 1'b1;
    end
    if (wr_buf && slave_mode && tx_busy_i)
    begin
      collide = 1'b1;
    end
  end

  // overflow: spi slave only, i2c receive only, never as spi master
  always_comb
  begin
    rx_overflow = 1'b0;
    if (rx_done_i && full_reg && !rd_buf)
    begin
      if (en_reg && dec_spi_s)
      begin
        rx_overflow = 1'b1;
      end
      else if (i2c_mode && !i2c_transmit_i)
      begin
        rx_overflow = 1'b1;
      end
    end
  end

  // register bank next state
  always_comb
  begin
    write_collision_flag_next = write_collision_flag_reg;
    ovf_next = ovf_reg;
    en_next = en_reg;
    ckp_next = ckp_reg;
    mode_next = mode_reg;
    reload_next = reload_reg;
    rxbuf_next = rxbuf_reg;
    full_next = full_reg;
    txbuf_next = txbuf_reg;
    load_next = 1'b0;
    if (wr_ctrl)
    begin
      write_collision_flag_next = write_collision_flag_reg & dat_i[serial_port_pkg::WRITE_COLLISION_FLAG_BIT];
      ovf_next = ovf_reg & dat_i[serial_port_pkg::OVF_BIT];
      en_next = dat_i[serial_port_pkg::EN_BIT];
      ckp_next = dat_i[serial_port_pkg::CKP_BIT];
      mode_next = dat_i[serial_port_pkg::MODE_LSB +: 4];
    end
    if (wr && (adr_i == serial_port_pkg::RELOAD_OFS))
    begin
      reload_next = dat_i[7:0];
    end
    if (wr_buf)
    begin
      txbuf_next = dat_i[7:0];
      load_next = en_reg & dec_valid & ~collide;
    end
    if (rd_buf)
    begin
      full_next = 1'b0;
    end
    // a new byte lands only when the buffer is free; overflow keeps old data
    if (rx_done_i && (spi_mode || i2c_mode))
    begin
      if (!full_reg || rd_buf)
      begin
        rxbuf_next = rx_data_i;
        full_next = 1'b1;
      end
    end
    // hardware set wins over a software clear in the same cycle
    if (collide)
    begin
      write_collision_flag_next = 1'b1;
    end
    if (rx_overflow)
    begin
      ovf_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      write_collision_flag_reg <= serial_port_pkg::CTRL_RESET[serial_port_pkg::WRITE_COLLISION_FLAG_BIT];
      ovf_reg <= serial_port_pkg::CTRL_RESET[serial_port_pkg::OVF_BIT];
      en_reg <= serial_port_pkg::CTRL_RESET[serial_port_pkg::EN_BIT];
      ckp_reg <= serial_port_pkg::CTRL_RESET[serial_port_pkg::CKP_BIT];
      mode_reg <= serial_port_pkg::CTRL_RESET[3:0];
      reload_reg <= serial_port_pkg::RELOAD_RESET;
      rxbuf_reg <= serial_port_pkg::BUF_RESET;
      full_reg <= 1'b0;
      txbuf_reg <= serial_port_pkg::BUF_RESET;
      load_reg <= 1'b0;
    end
    else
    begin
      write_collision_flag_reg <= write_collision_flag_next;
      ovf_reg <= ovf_next;
      en_reg <= en_next;
      ckp_reg <= ckp_next;
      mode_reg <= mode_next;
      reload_reg <= reload_next;
      rxbuf_reg <= rxbuf_next;
      full_reg <= full_next;
      txbuf_reg <= txbuf_next;
      load_reg <= load_next;
    end
  end

  // wishbone answer: ack one cycle after the request, dropped next cycle
  always_comb
  begin
    ack_next = cyc_i & stb_i & ~ack_reg;
    rdata_next = rdata_reg;
    if (ack_next)
    begin
      rdata_next = 32'h00000000;
      unique case (adr_i)
        serial_port_pkg::CTRL_OFS:
          rdata_next[7:0] = {write_collision_flag_reg, ovf_reg, en_reg, ckp_reg, mode_reg};
        serial_port_pkg::BUF_OFS: rdata_next[7:0] = rxbuf_reg;
        serial_port_pkg::RELOAD_OFS: rdata_next[7:0] = reload_reg;
        serial_port_pkg::STAT_OFS:
        begin
          rdata_next[serial_port_pkg::STAT_FULL_BIT] = full_reg;
          rdata_next[serial_port_pkg::STAT_VALID_BIT] = dec_valid;
          rdata_next[serial_port_pkg::STAT_BUSY_BIT] = tx_busy_i;
        end
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // master clock phase; returns to idle whenever no transfer runs
  always_comb
  begin
    sck_tog_next = sck_tog_reg;
    if (!(en_reg && tx_busy_i && (dec_spi_m || dec_i2c_mhw)))
    begin
      sck_tog_next = 1'b0;
    end
    else if (tick)
    begin
      sck_tog_next = ~sck_tog_reg;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sck_tog_reg <= 1'b0;
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end
    else
    begin
      sck_tog_reg <= sck_tog_next;
      pin_meta_reg <= pin_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // pin steering: direction stays with the port direction bits, except sda and scl in i2c
  always_comb
  begin
    pin_o = gpio_out_i;
    pin_oe_n_o = gpio_oe_n_i;
    if (spi_mode)
    begin
      // spi idles at the polarity level and toggles from it
      pin_o[serial_port_pkg::PIN_SCK] = ckp_reg ^ sck_tog_reg;
      pin_o[serial_port_pkg::PIN_SDO] = sdo_bit_i;
      pin_o[serial_port_pkg::PIN_SDI] = 1'b0;
      if (dec_ss_used)
      begin
        pin_o[serial_port_pkg::PIN_SS] = 1'b0;
      end
    end
    if (i2c_mode)
    begin
      // open drain: only ever pull low, released lines float high
      pin_o[serial_port_pkg::PIN_SDA] = 1'b0;
      pin_o[serial_port_pkg::PIN_SCL] = 1'b0;
      pin_oe_n_o[serial_port_pkg::PIN_SDA] = ~sda_low_i;
      pin_oe_n_o[serial_port_pkg::PIN_SCL] = 1'b1;
      if (dec_i2c_s)
      begin
        pin_oe_n_o[serial_port_pkg::PIN_SCL] = ckp_reg;
      end
      else if (dec_i2c_mhw)
      begin
        pin_oe_n_o[serial_port_pkg::PIN_SCL] = ~(tx_busy_i & ~sck_tog_reg);
      end
    end
  end

  // synchronised pin levels go to both the port and the serial logic
  assign gpio_in_o = pin_sync_reg;
  assign sck_in_o = pin_sync_reg[serial_port_pkg::PIN_SCK];
  assign sdi_in_o = pin_sync_reg[serial_port_pkg::PIN_SDI] & spi_mode;
  assign ss_active_o = en_reg & dec_spi_s & (~dec_ss_used | ~pin_sync_reg[serial_port_pkg::PIN_SS]);
  assign sda_in_o = pin_sync_reg[serial_port_pkg::PIN_SDA];
  assign scl_in_o = pin_sync_reg[serial_port_pkg::PIN_SCL];

  // decoded mode and transfer controls to the datapath
  assign spi_master_o = en_reg & dec_spi_m;
  assign spi_slave_o = en_reg & dec_spi_s;
  assign i2c_slave_o = en_reg & dec_i2c_s;
  assign i2c_ten_bit_o = en_reg & dec_i2c_s & dec_i2c_10;
  assign i2c_master_o = en_reg & dec_i2c_mhw;
  assign master_tick_o = tick;
  assign tx_load_o = load_reg;
  assign tx_data_o = txbuf_reg;
  assign ack_o = ack_reg;
  assign dat_o = rdata_reg;

endmodule

// ===== inc/serial_port_pkg.sv
/*
  shared constants for the serial port control block: register offsets,
  control field positions, reset values, mode codes, pin indices and
  clock divider half periods.
  assumes a 32-bit classic wishbone register bus and a 200 MHz clock.
*/
package serial_port_pkg;

  // register byte offsets within the block
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] BUF_OFS = 4'h4;
  localparam logic [3:0] RELOAD_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS = 4'hC;

  // control register field positions
  localparam int WRITE_COLLISION_FLAG_BIT = 7;
  localparam int OVF_BIT = 6;
  localparam int EN_BIT = 5;
  localparam int CKP_BIT = 4;
  localparam int MODE_LSB = 0;

  // status register field positions
  localparam int STAT_FULL_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [7:0] BUF_RESET = 8'h00;

  // operating mode codes
  typedef enum logic [3:0] {
    MODE_SPI_M_DIV4 = 4'b0000,
    MODE_SPI_M_DIV16 = 4'b0001,
    MODE_SPI_M_DIV64 = 4'b0010,
    MODE_SPI_M_TIMER = 4'b0011,
    MODE_SPI_S_SS = 4'b0100,
    MODE_SPI_S_NOSS = 4'b0101,
    MODE_I2C_S_7 = 4'b0110,
    MODE_I2C_S_10 = 4'b0111,
    MODE_I2C_M_RELOAD = 4'b1000,
    MODE_RSVD_9 = 4'b1001,
    MODE_SPI_M_RELOAD = 4'b1010,
    MODE_I2C_M_FW = 4'b1011,
    MODE_RSVD_C = 4'b1100,
    MODE_RSVD_D = 4'b1101,
    MODE_I2C_S_7_SP = 4'b1110,
    MODE_I2C_S_10_SP = 4'b1111
  } port_mode_e;

  // clock source selection for the master clock divider
  typedef enum logic [1:0] {
    CLK_SRC_FIXED = 2'b00,
    CLK_SRC_TIMER = 2'b01,
    CLK_SRC_RELOAD = 2'b10
  } clk_src_e;

  // pin indices
  localparam int PIN_SCK = 0;
  localparam int PIN_SDO = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_SS = 3;
  localparam int PIN_SDA = 4;
  localparam int PIN_SCL = 5;
  localparam int PIN_N = 6;

  // clock half periods in system cycles for divide by 4, 16 and 64
  localparam int DIV_W = 10;
  localparam logic [DIV_W-1:0] HALF_DIV4 = 10'h002;
  localparam logic [DIV_W-1:0] HALF_DIV16 = 10'h008;
  localparam logic [DIV_W-1:0] HALF_DIV64 = 10'h020;

endpackage

// ===== verilog/port_mode_decode.sv
/*
  decodes the four-bit mode field into operating mode strobes and the
  master clock source and rate.
  assumes a purely combinational use on the system clock.
*/
`timescale 1ns/1ps
module port_mode_decode
(
  // mode field
  input wire logic [3:0] mode_i,
  // decoded mode
  output logic spi_master_o,
  output logic spi_slave_o,
  output logic ss_used_o,
  output logic i2c_slave_o,
  output logic i2c_ten_bit_o,
  output logic i2c_master_hw_o,
  output logic i2c_master_fw_o,
  output logic mode_valid_o,
  // master clock choice
  output serial_port_pkg::clk_src_e clk_src_o,
  output logic [serial_port_pkg::DIV_W-1:0] fixed_half_o
);

  always_comb
  begin
    spi_master_o = 1'b0;
    spi_slave_o = 1'b0;
    ss_used_o = 1'b0;
    i2c_slave_o = 1'b0;
    i2c_ten_bit_o = 1'b0;
    i2c_master_hw_o = 1'b0;
    i2c_master_fw_o = 1'b0;
    clk_src_o = serial_port_pkg::CLK_SRC_FIXED;
    fixed_half_o = serial_port_pkg::HALF_DIV4;
    unique case (serial_port_pkg::port_mode_e'(mode_i))
      serial_port_pkg::MODE_SPI_M_DIV4: spi_master_o = 1'b1;
      serial_port_pkg::MODE_SPI_M_DIV16:
      begin
        spi_master_o = 1'b1;
        fixed_half_o = serial_port_pkg::HALF_DIV16;
      end
      serial_port_pkg::MODE_SPI_M_DIV64:
      begin
        spi_master_o = 1'b1;
        fixed_half_o = serial_port_pkg::HALF_DIV64;
      end
      serial_port_pkg::MODE_SPI_M_TIMER:
      begin
        spi_master_o = 1'b1;
        clk_src_o = serial_port_pkg::CLK_SRC_TIMER;
      end
      serial_port_pkg::MODE_SPI_S_SS:
      begin
        spi_slave_o = 1'b1;
        ss_used_o = 1'b1;
      end
      serial_port_pkg::MODE_SPI_S_NOSS: spi_slave_o = 1'b1;
      serial_port_pkg::MODE_I2C_S_7, serial_port_pkg::MODE_I2C_S_7_SP:
        i2c_slave_o = 1'b1;
      serial_port_pkg::MODE_I2C_S_10, serial_port_pkg::MODE_I2C_S_10_SP:
      begin
        i2c_slave_o = 1'b1;
        i2c_ten_bit_o = 1'b1;
      end
      serial_port_pkg::MODE_I2C_M_RELOAD:
      begin
        i2c_master_hw_o = 1'b1;
        clk_src_o = serial_port_pkg::CLK_SRC_RELOAD;
      end
      serial_port_pkg::MODE_SPI_M_RELOAD:
      begin
        spi_master_o = 1'b1;
        clk_src_o = serial_port_pkg::CLK_SRC_RELOAD;
      end
      serial_port_pkg::MODE_I2C_M_FW: i2c_master_fw_o = 1'b1;
      default: ;
    endcase
    mode_valid_o = spi_master_o | spi_slave_o | i2c_slave_o | i2c_master_hw_o
      | i2c_master_fw_o;
  end

endmodule

// ===== verilog/clock_tick_divider.sv
/*
  produces one-cycle tick pulses, one per half period of the serial
  master clock, from a fixed rate, a timer pulse or the reload value.
  assumes timer_pulse_i is a one-cycle pulse on clk_i.
*/
`timescale 1ns/1ps
module clock_tick_divider
#(
  parameter int DIV_W = serial_port_pkg::DIV_W
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire serial_port_pkg::clk_src_e src_i,
  input wire logic [DIV_W-1:0] fixed_half_i,
  input wire logic [7:0] reload_i,
  input wire logic timer_pulse_i,
  // tick out
  output logic tick_o
);

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic [DIV_W-1:0] half;
  logic tick_next;
  logic tick_reg;

  // half period of fosc/(4*(reload+1)) is 2*(reload+1) cycles
  function automatic logic [DIV_W-1:0] reload_half(input logic [7:0] r);
    reload_half = DIV_W'({r, 1'b0}) + DIV_W'(2);
  endfunction

  always_comb
  begin
    half = (src_i == serial_port_pkg::CLK_SRC_RELOAD) ? reload_half(reload_i) : fixed_half_i;
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!run_i)
    begin
      cnt_next = '0;
    end
    else if (src_i == serial_port_pkg::CLK_SRC_TIMER)
    begin
      tick_next = timer_pulse_i;
    end
    else if (cnt_reg >= half - DIV_W'(1))
    begin
      cnt_next = '0;
      tick_next = 1'b1;
    end
    else
    begin
      cnt_next = cnt_reg + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule

// ===== dv/serial_port_control_props.sv
/*
  port assertions for serial_port_control, using a shadow of the control
  register that is rebuilt from wishbone writes.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module serial_port_control_props
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // datapath and pins
  input wire logic start_ok_i,
  input wire logic tx_busy_i,
  input wire logic tx_load_o,
  input wire logic [7:0] tx_data_o,
  input wire logic spi_master_o,
  input wire logic i2c_slave_o,
  input wire logic i2c_master_o,
  input wire logic [serial_port_pkg::PIN_N-1:0] gpio_out_i,
  input wire logic [serial_port_pkg::PIN_N-1:0] gpio_oe_n_i,
  input wire logic [serial_port_pkg::PIN_N-1:0] pin_o,
  input wire logic [serial_port_pkg::PIN_N-1:0] pin_oe_n_o
);
  logic [5:0] ctrl_reg;
  logic [5:0] ctrl_next;
  logic acc;
  logic fwbuf;
  logic en;
  logic [3:0] md;
  logic [7:0] wbyte;
  assign acc = cyc_i && stb_i && ack_o;
  assign en = ctrl_reg[5];
  assign md = ctrl_reg[3:0];
  assign wbyte = dat_i[7:0];
  assign fwbuf = acc && we_i && sel_i[0] && adr_i == serial_port_pkg::BUF_OFS && en && md == 4'hB;
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (acc && we_i && sel_i[0] && adr_i == serial_port_pkg::CTRL_OFS)
      ctrl_next = dat_i[5:0];
  end
  always_ff @(posedge clk_i)
  begin
    ctrl_reg <= rst_i ? 6'h00 : ctrl_next;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  a_port_off: assert property (!en || md inside {4'h9, 4'hC, 4'hD} |->
    pin_o == gpio_out_i && pin_oe_n_o == gpio_oe_n_i)
    else $error("pins not returned to general use");
  a_spi_master_dec: assert property (spi_master_o == (en && md inside {[4'h0:4'h3], 4'hA}))
    else $error("spi master decode wrong");
  a_sck_idle: assert property (en && md inside {[4'h0:4'h2]} && !tx_busy_i
    && !$past(tx_busy_i) && $stable(ctrl_reg) |-> pin_o[0] == ctrl_reg[4])
    else $error("idle clock level differs from polarity");
  a_slave_stretch: assert property (en && md inside {4'h6, 4'h7, 4'hE, 4'hF} |->
    pin_oe_n_o[5] == ctrl_reg[4] && !pin_o[5])
    else $error("slave clock hold wrong");
  a_fw_master: assert property (en && md == 4'hB |->
    pin_oe_n_o[5] && !i2c_slave_o && !i2c_master_o)
    else $error("firmware master drives clock or slave");
  a_write_collision_flag_noload: assert property (fwbuf && !start_ok_i |=> !tx_load_o)
    else $error("blocked buffer write was loaded");
  a_load_data: assert property (fwbuf && start_ok_i |=> tx_load_o && tx_data_o == $past(wbyte))
    else $error("buffer write not loaded");
  a_master_no_ovf: assert property (acc && !we_i && adr_i == serial_port_pkg::CTRL_OFS
    && spi_master_o |-> !dat_o[6])
    else $error("overflow seen in spi master");
endmodule
bind serial_port_control serial_port_control_props serial_port_control_props_inst (.clk_i,
  .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .start_ok_i,
  .tx_busy_i, .tx_load_o, .tx_data_o, .spi_master_o, .i2c_slave_o, .i2c_master_o,
  .gpio_out_i, .gpio_oe_n_i, .pin_o, .pin_oe_n_o);

// ===== dv/ext_bus_model.sv
/*
  far side of the serial pads: pull-ups on sda and scl, an outside
  master's select on ss, a changing pattern on other released pads.
  assumes the pin order of serial_port_pkg.
*/
`timescale 1ns/1ps
module ext_bus_model
(
  // clock
  input wire logic clk_i,
  // pads as driven by the block
  input wire logic [serial_port_pkg::PIN_N-1:0] pad_drv_i,
  input wire logic [serial_port_pkg::PIN_N-1:0] pad_oe_n_i,
  // outside master selects the port
  input wire logic ss_sel_i,
  // resolved pad levels
  output logic [serial_port_pkg::PIN_N-1:0] pad_o
);
  logic tog_reg = 1'b0;
  logic tog_next;
  always_comb
  begin
    tog_next = !tog_reg;
    for (int i = 0; i < serial_port_pkg::PIN_N; i++)
      pad_o[i] = pad_oe_n_i[i] ? tog_reg : pad_drv_i[i];
    if (pad_oe_n_i[serial_port_pkg::PIN_SS])
      pad_o[serial_port_pkg::PIN_SS] = !ss_sel_i;
    // released open-drain lines float high
    if (pad_oe_n_i[serial_port_pkg::PIN_SDA])
      pad_o[serial_port_pkg::PIN_SDA] = 1'b1;
    if (pad_oe_n_i[serial_port_pkg::PIN_SCL])
      pad_o[serial_port_pkg::PIN_SCL] = 1'b1;
  end
  always_ff @(posedge clk_i)
  begin
    tog_reg <= tog_next;
  end
endmodule

// ===== dv/serial_port_control_bench.sv
/*
  self-checking bench: register reset, mode decode rows, clock rates,
  collision and overflow flags, pin steering.
  assumes ext_bus_model on the pads and the bound checker.
*/
`timescale 1ns/1ps
module serial_port_control_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
  logic [31:0] dat_i = 32'h00000000, dat_o, q;
  logic start_ok_i = 1'b0, tx_busy_i = 1'b0, i2c_transmit_i = 1'b0, rx_done_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00, tx_data_o;
  logic sdo_bit_i = 1'b0, sda_low_i = 1'b0, timer_pulse_i = 1'b0, ss_sel_i = 1'b0, s;
  logic ack_o, tx_load_o, master_tick_o, sck_in_o, sdi_in_o, ss_active_o, sda_in_o, scl_in_o;
  logic spi_master_o, spi_slave_o, i2c_slave_o, i2c_ten_bit_o, i2c_master_o;
  logic [5:0] gpio_out_i = 6'h2A, gpio_oe_n_i = 6'h3C;
  logic [5:0] gpio_in_o, pin_i, pin_o, pin_oe_n_o;
  wire [4:0] dec = {spi_master_o, spi_slave_o, i2c_slave_o, i2c_master_o, i2c_ten_bit_o};
  int fails = 0, num_checks = 0, n;
  // mode code beside the decode it should give
  logic [8:0] rows [16] = '{9'h010, 9'h030, 9'h050, 9'h070, 9'h088, 9'h0A8, 9'h0C4, 9'h0E5,
    9'h102, 9'h120, 9'h150, 9'h160, 9'h180, 9'h1A0, 9'h1C4, 9'h1E5};
  serial_port_control serial_port_control_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .start_ok_i, .tx_busy_i, .i2c_transmit_i, .rx_done_i,
    .rx_data_i, .sdo_bit_i, .sda_low_i, .timer_pulse_i, .tx_load_o, .tx_data_o, .master_tick_o,
    .sck_in_o, .sdi_in_o, .ss_active_o, .sda_in_o, .scl_in_o, .spi_master_o, .spi_slave_o,
    .i2c_slave_o, .i2c_ten_bit_o, .i2c_master_o, .gpio_out_i, .gpio_oe_n_i, .gpio_in_o,
    .pin_i, .pin_o, .pin_oe_n_o);
  ext_bus_model ext_bus_model_inst (.clk_i, .pad_drv_i(pin_o), .pad_oe_n_i(pin_oe_n_o),
    .ss_sel_i, .pad_o(pin_i));
  initial
    forever #2.5 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    num_checks++;
    if (v !== e)
    begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, v, e);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      @(posedge clk_i);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, {24'h000000, e});
  endtask
  task automatic ctl(input logic [7:0] d); wb(1'b1, serial_port_pkg::CTRL_OFS, d); endtask
  task automatic rctl(input logic [7:0] e); rd(serial_port_pkg::CTRL_OFS, e); endtask
  task automatic rx(input logic [7:0] d);
    @(posedge clk_i);
    rx_done_i <= 1'b1;
    rx_data_i <= d;
    @(posedge clk_i);
    rx_done_i <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    close_out;
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rctl(serial_port_pkg::CTRL_RESET);
    rd(serial_port_pkg::RELOAD_OFS, serial_port_pkg::RELOAD_RESET);
    wb(1'b1, serial_port_pkg::RELOAD_OFS, 8'h04);
    wb(1'b1, 4'h1, 8'hFF);
    rd(4'h1, 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      ctl({4'h2, rows[i][8:5]});
      #1;
      chk(dec, rows[i][4:0]);
    end
    $display("reset and decode done");
    for (int m = 0; m < 4; m++)
    begin
      ctl(8'h30 | (m < 3 ? 8'(m) : 8'h0A));
      #1;
      chk(pin_o[0], 1'b1);
      @(posedge clk_i);
      tx_busy_i <= 1'b1;
      for (int k = 0; k < 2; k++)
      begin
        s = pin_o[0];
        n = 0;
        while (pin_o[0] === s && n < 100)
        begin
          @(posedge clk_i);
          n++;
        end
      end
      chk(n, m < 3 ? 2 << (2 * m) : 10);
      @(posedge clk_i);
      tx_busy_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
      chk(pin_o[0], 1'b1);
    end
    $display("clock rates done");
    ctl(8'h2B);
    wb(1'b1, serial_port_pkg::BUF_OFS, 8'h5A);
    rctl(8'hAB);
    ctl(8'h2B);
    rctl(8'h2B);
    @(posedge clk_i);
    start_ok_i <= 1'b1;
    wb(1'b1, serial_port_pkg::BUF_OFS, 8'hA5);
    rctl(8'h2B);
    chk(tx_data_o, 8'hA5);
    gpio_oe_n_i <= 6'h3E;
    ctl(8'h24);
    #1;
    chk(ss_active_o, 1'b0);
    @(posedge clk_i);
    tx_busy_i <= 1'b1;
    wb(1'b1, serial_port_pkg::BUF_OFS, 8'h3C);
    rctl(8'hA4);
    tx_busy_i <= 1'b0;
    $display("collision done");
    ctl(8'h25);
    rx(8'h11);
    rx(8'h22);
    rctl(8'h65);
    chk(ss_active_o, 1'b1);
    rd(serial_port_pkg::BUF_OFS, 8'h11);
    ctl(8'h20);
    rx(8'h33);
    rx(8'h44);
    rctl(8'h20);
    rd(serial_port_pkg::BUF_OFS, 8'h33);
    ctl(8'h36);
    sda_low_i <= 1'b1;
    rx(8'h55);
    i2c_transmit_i <= 1'b1;
    rx(8'h66);
    rctl(8'h36);
    chk(pin_oe_n_o[5:4], 2'b10);
    chk({sda_in_o, scl_in_o}, 2'b01);
    i2c_transmit_i <= 1'b0;
    rx(8'h77);
    rctl(8'h76);
    rd(serial_port_pkg::BUF_OFS, 8'h55);
    ctl(8'h26);
    #1;
    chk(pin_oe_n_o[5], 1'b0);
    $display("overflow and i2c done");
    ctl(8'h38);
    #1;
    chk(pin_oe_n_o[5], 1'b1);
    ctl(8'h28);
    #1;
    chk(pin_oe_n_o[5], 1'b1);
    ctl(8'h00);
    #1;
    chk({pin_o, pin_oe_n_o}, {gpio_out_i, gpio_oe_n_i});
    repeat (3) @(posedge clk_i);
    chk(gpio_in_o[5:3], 3'b111);
    $display("master and disable done");
    close_out;
  end
endmodule
